// >>> usbdc_cfg_pkg.sv
/*
  Constants shared by both ends of the device-controller configuration link:
  command codes, register field positions, reset values and timing counts.
  Assumes one 20 MHz clock common to both ends.
*/
package usbdc_cfg_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned IRQ_PULSE_NS    = 166;
  // least width, rounded up to whole cycles
  localparam int unsigned IRQ_PULSE_CYC   =
    (IRQ_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned PULSE_CNT_W     = 3;

  // ----------------------------------------------------------------
  // command codes on the parallel bus
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_IEN_WR       = 8'hC2;
  localparam logic [7:0] CMD_IEN_RD       = 8'hC3;
  localparam logic [7:0] CMD_DMA_WR       = 8'hF0;
  localparam logic [7:0] CMD_DMA_RD       = 8'hF1;
  localparam int unsigned IEN_WORDS       = 2;
  localparam int unsigned DMA_WORDS       = 1;

  // ----------------------------------------------------------------
  // interrupt-enable register layout
  // ----------------------------------------------------------------
  localparam int unsigned IEN_W           = 32;
  localparam logic [31:0] IEN_RESET       = 32'h0000_0000;
  localparam int unsigned EV_W            = 24;
  localparam int unsigned IEN_EP_LSB      = 10;
  localparam int unsigned IEN_EP0IN_BIT   = 9;
  localparam int unsigned IEN_EP0OUT_BIT  = 8;
  localparam int unsigned IEN_SHORT_BIT   = 6;
  localparam int unsigned IEN_PSOF_BIT    = 5;
  localparam int unsigned IEN_SOF_BIT     = 4;
  localparam int unsigned IEN_EOT_BIT     = 3;
  localparam int unsigned IEN_SUSP_BIT    = 2;
  localparam int unsigned IEN_RESM_BIT    = 1;
  localparam int unsigned IEN_RST_BIT     = 0;
  // bit 7 and bits 31:24 carry no event
  localparam logic [23:0] EV_MASK         = 24'hFF_FF7F;

  // ----------------------------------------------------------------
  // dma setup register layout
  // ----------------------------------------------------------------
  localparam logic [15:0] DMA_RESET       = 16'h0000;
  localparam logic [15:0] DMA_WR_MASK     = 16'hFEFF;
  localparam int unsigned DMA_CNTEN_BIT   = 15;
  localparam int unsigned DMA_SHORT_BIT   = 14;
  localparam int unsigned DMA_WORD_BIT    = 8;
  localparam int unsigned DMA_EP_LSB      = 4;
  localparam int unsigned DMA_RUN_BIT     = 3;
  localparam int unsigned DMA_BURST_LSB   = 0;

  // ----------------------------------------------------------------
  // host-side avalon register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] AV_CMD           = 4'h0;
  localparam logic [3:0] AV_WDATA         = 4'h4;
  localparam logic [3:0] AV_RDATA         = 4'h8;
  localparam logic [3:0] AV_STATUS        = 4'hC;
  localparam int unsigned AV_GO_BIT       = 0;
  localparam int unsigned AV_WRITE_BIT    = 1;
  localparam int unsigned AV_SEL_BIT      = 2;
  localparam int unsigned AV_DWORD_BIT    = 3;
  localparam logic [31:0] AV_UNMAPPED     = 32'h0000_0000;

  // burst size in bytes from the two-bit field
  function automatic logic [4:0] burst_bytes(input logic [1:0] sel);
    case (sel)
      2'h0:    burst_bytes = 5'h01;
      2'h1:    burst_bytes = 5'h04;
      2'h2:    burst_bytes = 5'h08;
      default: burst_bytes = 5'h10;
    endcase
  endfunction
endpackage

// >>> usbdc_cfg_if.sv
/*
  Link between the microprocessor end and the device-controller end:
  command/data strobes, the shared 16-bit data bus, dma handshake and the
  interrupt line. Both ends run on the same clock; the data bus level is
  resolved here from the two output enables.
*/
`timescale 1ns/1ps
interface usbdc_cfg_if;
  logic        cmd_wr;       // command phase write strobe (code in low byte)
  logic        dat_wr;       // data phase write strobe
  logic        dat_rd;       // data phase read strobe
  logic [15:0] host_d;
  logic        host_d_oe;
  logic [15:0] dev_d;
  logic        dev_d_oe;
  logic [15:0] bus_d;
  logic        dma_req;      // device asks for a dma access
  logic        dma_ack;      // dma controller grants one access
  logic        dma_word;     // granted access carries a full word
  logic        dma_eot;      // external end-of-transfer from dma controller
  logic        irq;          // device interrupt output

  // wire level worked out from the enables; undriven bus reads as zero
  assign bus_d = dev_d_oe ? dev_d : (host_d_oe ? host_d : 16'h0000);

  modport host (
    output cmd_wr, dat_wr, dat_rd, host_d, host_d_oe, dma_ack, dma_word, dma_eot,
    input  bus_d, dma_req, irq
  );
  modport dev (
    input  cmd_wr, dat_wr, dat_rd, bus_d, dma_ack, dma_word, dma_eot,
    output dev_d, dev_d_oe, dma_req, irq
  );
endinterface

// >>> usbdc_cfg_dev.sv
/*
  Device-controller end: interrupt-enable register with event capture and
  interrupt output, and dma setup register with the dma run/end logic.
  Assumes the microprocessor follows each command with the right number of
  data strobes, and that all user-side inputs are on core_clk_i.
*/
// Added by the designer: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps

// Notes on behaviour
// RL1: disabled events never reach the interrupt output
// RL2: events already in progress stay unreported
// RL3: status latches only enabled events; no masking
// RL4: bus reset keeps interrupt enables
// RL5: C2 writes, C3 reads enables, two words
// RL6: software writes zero to bits 31:24
// RL7: bits 23:8 enable endpoint interrupts
// RL8: bits 6:3 enable packet, frame, transfer-end
// RL9: bits 2:0 enable suspend, resume, bus reset
// RL10: F0 writes, F1 reads dma setup, one word
// RL11: bus reset clears only dma run
// RL12: counter zero ends transfer when enabled
// RL13: short OUT packet ends transfer when enabled
// RL14: bit 8 shows last access byte or word
// RL15: bits 7:4 select dma endpoint
// RL16: bit 3 starts, stops, reports dma
// RL17: bits 1:0 select burst of 1/4/8/16
// RL18: dma enable reloads byte counter
// RL19: pulse mode gives one pulse of at least 166 ns, 4 cycles (200 ns)
// RL20: level mode holds while latched bits remain
// RL21: any transfer end stops dma
module usbdc_cfg_dev
  import usbdc_cfg_pkg::*;
(
  // clock and reset
  input  wire logic                 core_clk_i,
  input  wire logic                 rst_n_i,
  // link to the microprocessor and dma controller
  usbdc_cfg_if.dev                  link,
  // device core events and controls
  input  wire logic [EV_W-1:0]      event_i,
  input  wire logic [EV_W-1:0]      status_clr_i,
  input  wire logic                 bus_reset_i,
  input  wire logic                 irq_pulse_select_i,
  input  wire logic [15:0]          dma_byte_count_i,
  input  wire logic                 short_packet_i,
  // state for the device core
  output logic [EV_W-1:0]           irq_status_latch_o,
  output logic [15:0]               dma_remaining_o,
  output logic [3:0]                dma_endpoint_index_o,
  output logic [4:0]                dma_burst_bytes_o,
  output logic                      transfer_end_condition_o
);
  import usbdc_cfg_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]        cmd_q;
  logic [1:0]        word_q;
  logic [15:0]       low_q;
  logic [IEN_W-1:0]  irq_enable_gate_q;
  logic [15:0]       dma_setup_q;
  logic              last_access_word_flag_q;
  logic [15:0]       cnt_q;
  logic [4:0]        burst_q;
  logic              burst_gap_q;
  logic [EV_W-1:0]   ev_prev_q;
  logic [EV_W-1:0]   stat_q;
  logic [PULSE_CNT_W-1:0] pulse_q;
  logic              irq_q;
  logic              eot_q;
  logic [15:0]       rd_q;
  logic              rd_oe_q;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  wire ien_wr_last = link.dat_wr && (cmd_q == CMD_IEN_WR)
                     && (word_q == 2'(IEN_WORDS - 1));
  wire ien_wr_low  = link.dat_wr && (cmd_q == CMD_IEN_WR) && (word_q == 2'h0);
  wire dma_wr      = link.dat_wr && (cmd_q == CMD_DMA_WR)
                     && (word_q == 2'(DMA_WORDS - 1));
  wire [15:0] wdat = link.bus_d;

  // ----------------------------------------------------------------
  // dma run and end-of-transfer
  // ----------------------------------------------------------------
  wire dma_run      = dma_setup_q[DMA_RUN_BIT];
  wire wr_run       = dma_wr && wdat[DMA_RUN_BIT];
  wire start_dma    = wr_run && !dma_run;
  wire access       = link.dma_ack && link.dma_req;
  wire [15:0] step  = link.dma_word ? 16'h0002 : 16'h0001;
  wire [15:0] cnt_d = start_dma ? dma_byte_count_i                 // see RL18
                    : (access ? ((cnt_q > step) ? cnt_q - step : 16'h0000) : cnt_q);
  wire cnt_end      = access && (cnt_d == 16'h0000)
                      && dma_setup_q[DMA_CNTEN_BIT];               // see RL12
  wire short_end    = dma_run && short_packet_i
                      && dma_setup_q[DMA_SHORT_BIT];               // see RL13
  wire ext_end      = dma_run && link.dma_eot;
  wire eot_now      = cnt_end || short_end || ext_end;
  wire [4:0] bsize  = burst_bytes(dma_setup_q[1:0]);               // see RL17
  // the burst size counts bytes, so a word access uses up two of them
  wire [4:0] abytes = link.dma_word ? 5'h02 : 5'h01;
  wire burst_done   = access && (burst_q + abytes >= bsize);

  // register writes; bus reset touches only the run bit
  wire [15:0] dma_new = (wdat & DMA_WR_MASK) | (dma_setup_q & ~DMA_WR_MASK);
  logic [15:0] dma_setup_d;
  always_comb
  begin
    dma_setup_d = dma_wr ? dma_new : dma_setup_q;                  // see RL10
    if (bus_reset_i || eot_now)
    begin
      dma_setup_d[DMA_RUN_BIT] = 1'b0;                             // see RL11, RL21
    end
    if (dma_wr && !wdat[DMA_RUN_BIT])
    begin
      dma_setup_d[DMA_RUN_BIT] = 1'b0;                             // see RL16
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      dma_setup_q             <= DMA_RESET;
      last_access_word_flag_q <= 1'b0;
      cnt_q                   <= 16'h0000;
      burst_q                 <= 5'h00;
      burst_gap_q             <= 1'b0;
      eot_q                   <= 1'b0;
    end
    else
    begin
      dma_setup_q <= dma_setup_d;
      cnt_q       <= cnt_d;
      eot_q       <= eot_now;
      burst_gap_q <= burst_done;
      burst_q     <= (burst_done || !dma_run) ? 5'h00 : (access ? burst_q + abytes : burst_q);
      if (access)
      begin
        last_access_word_flag_q <= link.dma_word;                  // see RL14
      end
    end
  end

  // request drops for one cycle after each burst
  assign link.dma_req = dma_run && !burst_gap_q && (cnt_q != 16'h0000);

  // ----------------------------------------------------------------
  // interrupt enables and event capture
  // ----------------------------------------------------------------
  logic [EV_W-1:0] ev_in;
  always_comb
  begin
    ev_in = event_i;
    ev_in[IEN_EOT_BIT] = event_i[IEN_EOT_BIT] | eot_q;
  end
  // only a rising edge counts, so an event already high is never caught
  wire [EV_W-1:0] ev_rise  = ev_in & ~ev_prev_q;                   // see RL2
  wire [EV_W-1:0] capture  = ev_rise & irq_enable_gate_q[EV_W-1:0]
                             & EV_MASK;                            // see RL1, RL7, RL8, RL9
  // set wins over clear; enables never mask what is latched
  wire [EV_W-1:0] stat_d   = (stat_q & ~status_clr_i) | capture;   // see RL3
  wire            new_irq  = |capture;

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      irq_enable_gate_q <= IEN_RESET;
      low_q             <= 16'h0000;
      ev_prev_q         <= '0;
      stat_q            <= '0;
    end
    else
    begin
      // bus reset deliberately not looked at here
      if (ien_wr_low)
      begin
        low_q <= wdat;
      end
      if (ien_wr_last)
      begin
        irq_enable_gate_q <= {wdat, low_q};                        // see RL4, RL5
      end
      ev_prev_q <= ev_in;
      stat_q    <= stat_d;
    end
  end

  // ----------------------------------------------------------------
  // interrupt output
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pulse_q <= '0;
      irq_q   <= 1'b0;
    end
    else
    begin
      if (new_irq)
      begin
        pulse_q <= PULSE_CNT_W'(IRQ_PULSE_CYC);                    // see RL19
      end
      else if (pulse_q != '0)
      begin
        pulse_q <= pulse_q - 1'b1;
      end
      irq_q <= irq_pulse_select_i ? (new_irq || pulse_q > 1)
                                  : (|stat_d);                     // see RL20
    end
  end
  assign link.irq = irq_q;

  // ----------------------------------------------------------------
  // command and data phases
  // ----------------------------------------------------------------
  wire [15:0] dma_read = {dma_setup_q[15:9], last_access_word_flag_q, dma_setup_q[7:0]};
  wire        is_rd    = (link.bus_d[7:0] == CMD_IEN_RD) || (link.bus_d[7:0] == CMD_DMA_RD);

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cmd_q   <= 8'h00;
      word_q  <= 2'h0;
      rd_q    <= 16'h0000;
      rd_oe_q <= 1'b0;
    end
    else
    begin
      if (link.cmd_wr)
      begin
        cmd_q   <= link.bus_d[7:0];
        word_q  <= 2'h0;
        rd_oe_q <= is_rd;
        rd_q    <= (link.bus_d[7:0] == CMD_IEN_RD) ? irq_enable_gate_q[15:0]
                 : dma_read;                                       // see RL5, RL10
      end
      else if (link.dat_wr)
      begin
        word_q <= word_q + 2'h1;
      end
      else if (link.dat_rd)
      begin
        word_q  <= word_q + 2'h1;
        rd_q    <= irq_enable_gate_q[31:16];
        rd_oe_q <= (cmd_q == CMD_IEN_RD) && (word_q == 2'h0);
      end
    end
  end
  assign link.dev_d    = rd_q;
  assign link.dev_d_oe = rd_oe_q;

  // ----------------------------------------------------------------
  // user-side outputs
  // ----------------------------------------------------------------
  assign irq_status_latch_o       = stat_q;
  assign dma_remaining_o          = cnt_q;
  assign dma_endpoint_index_o     = dma_setup_q[7:4];              // see RL15
  assign dma_burst_bytes_o        = bsize;
  assign transfer_end_condition_o = eot_q;

endmodule // usbdc_cfg_dev

// >>> usbdc_cfg_host.sv
/*
  Microprocessor end: an Avalon-MM slave that turns software orders into
  command and data phases on the link, and a simple dma controller that
  grants one access per cycle while the device requests.
  Assumes the device end on the same clock.
*/
`timescale 1ns/1ps
module usbdc_cfg_host
  import usbdc_cfg_pkg::*;
(
  // clock and reset
  input  wire logic          core_clk_i,
  input  wire logic          rst_n_i,
  // avalon-mm slave
  input  wire logic [3:0]    avs_address_i,
  input  wire logic          avs_read_i,
  input  wire logic          avs_write_i,
  input  wire logic [31:0]   avs_writedata_i,
  output logic [31:0]        avs_readdata_o,
  output logic               avs_waitrequest_o,
  // link to the device
  usbdc_cfg_if.host          link,
  // dma side
  input  wire logic          dma_eot_i
);
  import usbdc_cfg_pkg::*;

  typedef enum logic [2:0] {IDLE, CMD, GAP, DATA, DONE} seq_t;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  seq_t         st_q;
  logic         wr_q;
  logic         sel_q;
  logic         dword_q;
  logic [1:0]   idx_q;
  logic [31:0]  wdata_q;
  logic [31:0]  rdata_q;
  logic [31:0]  rd_out_q;
  logic         rd_hold_q;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire busy      = (st_q != IDLE);
  wire go_wr     = avs_write_i && (avs_address_i == AV_CMD);
  wire [1:0] nw  = sel_q ? 2'(DMA_WORDS) : 2'(IEN_WORDS);
  wire [7:0] code = sel_q ? (wr_q ? CMD_DMA_WR : CMD_DMA_RD)
                          : (wr_q ? CMD_IEN_WR : CMD_IEN_RD);    // see RL5, RL10
  // a new order waits while one is still running; a read waits one cycle
  // so that its data comes from a flop
  assign avs_waitrequest_o = (go_wr && busy) || (avs_read_i && !rd_hold_q);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_q    <= IDLE;
      wr_q    <= 1'b0;
      sel_q   <= 1'b0;
      dword_q <= 1'b1;
      idx_q   <= 2'h0;
      wdata_q <= 32'h0000_0000;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      if (avs_write_i && avs_address_i == AV_WDATA)
      begin
        wdata_q <= avs_writedata_i & 32'h00FF_FFFF;              // see RL6
      end
      case (st_q)
        IDLE:
        begin
          if (go_wr && avs_writedata_i[AV_GO_BIT])
          begin
            wr_q    <= avs_writedata_i[AV_WRITE_BIT];
            sel_q   <= avs_writedata_i[AV_SEL_BIT];
            dword_q <= avs_writedata_i[AV_DWORD_BIT];
            st_q    <= CMD;
          end
          else if (go_wr)
          begin
            dword_q <= avs_writedata_i[AV_DWORD_BIT];
          end
        end
        CMD:
        begin
          idx_q <= 2'h0;
          st_q  <= GAP;
        end
        GAP:     st_q <= DATA;
        DATA:
        begin
          if (!wr_q)
          begin
            if (idx_q == 2'h0)
            begin
              rdata_q <= {16'h0000, link.bus_d};
            end
            else
            begin
              rdata_q[31:16] <= link.bus_d;
            end
          end
          idx_q <= idx_q + 2'h1;
          st_q  <= (idx_q + 2'h1 == nw) ? DONE : GAP;
        end
        DONE:    st_q <= IDLE;
        default: st_q <= IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // link drive
  // ----------------------------------------------------------------
  wire drv_cmd  = (st_q == CMD);
  wire drv_data = (st_q == DATA) && wr_q;
  assign link.cmd_wr    = drv_cmd;
  assign link.dat_wr    = drv_data;
  assign link.dat_rd    = (st_q == DATA) && !wr_q;
  assign link.host_d    = drv_cmd ? {8'h00, code}
                        : (idx_q == 2'h0 ? wdata_q[15:0] : wdata_q[31:16]);
  assign link.host_d_oe = drv_cmd || drv_data;

  // dma controller grants every request; width chosen by software
  assign link.dma_ack   = link.dma_req;
  assign link.dma_word  = dword_q;
  assign link.dma_eot   = dma_eot_i;

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  wire [31:0] rd_mux =
      (avs_address_i == AV_CMD)    ? {28'h000_0000, dword_q, sel_q, wr_q, busy}
    : (avs_address_i == AV_WDATA)  ? wdata_q
    : (avs_address_i == AV_RDATA)  ? rdata_q
    : (avs_address_i == AV_STATUS) ? {29'h0000_0000, link.dma_req, link.irq, busy}
    : AV_UNMAPPED;

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rd_out_q  <= 32'h0000_0000;
      rd_hold_q <= 1'b0;
    end
    else
    begin
      rd_hold_q <= avs_read_i && !rd_hold_q;
      if (avs_read_i)
      begin
        rd_out_q <= rd_mux;
      end
    end
  end
  // data caught in the wait cycle stands at the taking edge
  assign avs_readdata_o = rd_out_q;

endmodule // usbdc_cfg_host

// >>> usbdc_cfg_checker.sv
/*
  Link checker for the configuration interface.
  Assumes the interface signals on one clock, reset active low.
*/
`timescale 1ns/1ps
module usbdc_cfg_checker
  import usbdc_cfg_pkg::*;
(
  // clock and reset
  input wire logic        core_clk_i,
  input wire logic        rst_n_i,
  // link signals
  input wire logic        cmd_wr,
  input wire logic        dat_wr,
  input wire logic        dat_rd,
  input wire logic [15:0] bus_d,
  input wire logic        dev_d_oe,
  input wire logic        dma_req,
  input wire logic        dma_ack,
  input wire logic        dma_eot
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // command phase rules: one-cycle strobe, then a gap
  property p_cmd_pulse; cmd_wr |=> !cmd_wr; endproperty
  a_cmd_pulse: assert property (p_cmd_pulse) else $error("cmd strobe too long");
  property p_cmd_gap; cmd_wr |=> !(dat_wr || dat_rd); endproperty
  a_cmd_gap: assert property (p_cmd_gap) else $error("data right after cmd");
  property p_wr_rd; !(dat_wr && dat_rd); endproperty
  a_wr_rd: assert property (p_wr_rd) else $error("read and write strobes together");
  // the device must never fight the host on the data bus
  property p_wr_float; dat_wr |-> !dev_d_oe; endproperty
  a_wr_float: assert property (p_wr_float) else $error("device drives during write");
  property p_ien_rd; cmd_wr && bus_d[7:0] == CMD_IEN_RD |=> dev_d_oe; endproperty
  a_ien_rd: assert property (p_ien_rd) else $error("enable read not driven");
  property p_dma_rd; cmd_wr && bus_d[7:0] == CMD_DMA_RD |=> dev_d_oe; endproperty
  a_dma_rd: assert property (p_dma_rd) else $error("dma setup read not driven");
  property p_dma_wr; cmd_wr && bus_d[7:0] == CMD_DMA_WR |=> !dev_d_oe; endproperty
  a_dma_wr: assert property (p_dma_wr) else $error("dma setup write driven");
  // an end of transfer stops requests from the next cycle on
  property p_eot_stop; dma_eot |=> !dma_req; endproperty
  a_eot_stop: assert property (p_eot_stop) else $error("request after eot");
  property p_cmd_float; cmd_wr |-> !dev_d_oe; endproperty
  a_cmd_float: assert property (p_cmd_float) else $error("device drives during cmd");
endmodule // usbdc_cfg_checker

// >>> dev_ctrl_irq_enable_dma_config_tb.sv
/*
  Bench: host and device ends joined by the interface, driven over avalon-mm.
  Assumes the package's command layout and one 20 MHz clock.
*/
`timescale 1ns/1ps
module dev_ctrl_irq_enable_dma_config_tb;
  import usbdc_cfg_pkg::*;
  localparam logic [3:0] IW = 4'hB;
  localparam logic [3:0] IR = 4'h9;
  // bit 3 of an order picks word-wide dma accesses
  localparam logic [3:0] DW = 4'hF;
  localparam logic [3:0] DR = 4'hD;
  localparam logic [3:0] DB = 4'h7;
  logic        core_clk_i, rst_n_i, rd, wr, wreq, bus_rst, spk, transfer_end_condition, tend, psel;
  logic [3:0]  adr, epi;
  logic [31:0] wd, rdat, q;
  logic [23:0] ev, clr, st;
  logic [15:0] cnt, rem;
  logic [4:0]  bb;
  int          err_total, n_checks;
  usbdc_cfg_if link ();
  usbdc_cfg_host u_usbdc_cfg_host (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .link(link), .dma_eot_i(transfer_end_condition));
  usbdc_cfg_dev u_usbdc_cfg_dev (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .link(link),
    .event_i(ev), .status_clr_i(clr), .bus_reset_i(bus_rst), .irq_pulse_select_i(psel),
    .dma_byte_count_i(cnt), .short_packet_i(spk), .irq_status_latch_o(st),
    .dma_remaining_o(rem), .dma_endpoint_index_o(epi), .dma_burst_bytes_o(bb),
    .transfer_end_condition_o(tend));
  usbdc_cfg_checker u_usbdc_cfg_checker (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .cmd_wr(link.cmd_wr), .dat_wr(link.dat_wr), .dat_rd(link.dat_rd), .bus_d(link.bus_d),
    .dev_d_oe(link.dev_d_oe), .dma_req(link.dma_req), .dma_ack(link.dma_ack),
    .dma_eot(link.dma_eot));
  // 50 ns clock
  initial
  begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  // one avalon cycle; request held until waitrequest is seen low
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    do
    begin
      @(posedge core_clk_i);
    end
    while (wreq !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge core_clk_i);
  endtask
  // load data, give the order, poll busy, fetch the result into q
  task automatic xfer(input logic [3:0] c, input logic [31:0] d);
    av(1'b1, AV_WDATA, d);
    av(1'b1, AV_CMD, {28'h0, c});
    do
    begin
      av(1'b0, AV_CMD, 32'h0);
    end
    while (q[AV_GO_BIT] !== 1'b0);
    av(1'b0, AV_RDATA, 32'h0);
  endtask
  task automatic pulse_busrst();
    bus_rst <= 1'b1;
    @(posedge core_clk_i);
    bus_rst <= 1'b0;
  endtask
  task automatic t_ien();
    xfer(IW, 32'h00FF_FF7F);
    xfer(IR, 32'h0);
    chk("ien", 32'h00FF_FF7F, q);
    pulse_busrst();
    xfer(IR, 32'h0);
    chk("ien_busrst", 32'h00FF_FF7F, q);
    $display("t_ien done");
  endtask
  // events only latch when enabled beforehand; the line follows the latch
  task automatic t_gate();
    int n;
    xfer(IW, 32'h0000_0010);
    ev <= 24'h00_0024;
    repeat (3) @(posedge core_clk_i);
    chk("disabled", 32'h0, {8'h0, st});
    xfer(IW, 32'h0000_0014);
    chk("in_progress", 32'h0, {8'h0, st});
    ev <= 24'h00_0034;
    repeat (3) @(posedge core_clk_i);
    chk("latched", 32'h10, {8'h0, st});
    chk("irq_on", 32'h1, {31'h0, link.irq});
    clr <= 24'h00_0010;
    ev <= 24'h00_0000;
    @(posedge core_clk_i);
    clr <= 24'h00_0000;
    repeat (3) @(posedge core_clk_i);
    chk("irq_off", 32'h0, {31'h0, link.irq});
    // pulse mode: a fresh enabled event gives one pulse of the set width
    psel <= 1'b1;
    ev <= 24'h00_0010;
    n = 0;
    repeat (8)
    begin
      @(posedge core_clk_i);
      n += (link.irq === 1'b1);
    end
    chk("pulse_len", IRQ_PULSE_CYC, n);
    psel <= 1'b0;
    $display("t_gate done");
  endtask
  task automatic t_dma();
    logic [4:0] bt [4];
    int n;
    bt = '{5'h01, 5'h04, 5'h08, 5'h10};
    cnt <= 16'hFFFF;
    for (int b = 0; b < 4; b++)
    begin
      xfer(DW, {24'h0, 4'(b + 1), 2'b00, 2'(b)});
      chk("burst", {27'h0, bt[b]}, {27'h0, bb});
      chk("ep", 32'(b + 1), {28'h0, epi});
    end
    xfer(DW, 32'h0000_4029);
    chk("reload", 32'h1, {31'h0, rem > 16'hF000});
    xfer(DR, 32'h0);
    chk("run_on", 32'h4129, {16'h0, q[15:0]});
    pulse_busrst();
    xfer(DR, 32'h0);
    chk("busrst", 32'h4121, {16'h0, q[15:0]});
    xfer(DW, 32'h0000_4029);
    spk <= 1'b1;
    @(posedge core_clk_i);
    spk <= 1'b0;
    n = 0;
    do
    begin
      @(posedge core_clk_i);
      n++;
    end
    while (tend !== 1'b1 && n < 20);
    chk("short_end", 32'h1, {31'h0, tend});
    xfer(DW, 32'h0000_4029);
    transfer_end_condition <= 1'b1;
    @(posedge core_clk_i);
    transfer_end_condition <= 1'b0;
    xfer(DR, 32'h0);
    chk("eot_stop", 32'h4121, {16'h0, q[15:0]});
    // small count runs out long before the read-back finishes
    // byte accesses this time, so bit 8 reads back 0
    cnt <= 16'h0006;
    xfer(DB, 32'h0000_8009);
    xfer(DR, 32'h0);
    chk("count_end", 32'h8001, {16'h0, q[15:0]});
    chk("count_zero", 32'h0, {16'h0, rem});
    $display("t_dma done");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // watchdog: the tests need well under a few thousand cycles
  initial
  begin
    repeat (20000) @(posedge core_clk_i);
    err_total++;
    final_report();
  end
  initial
  begin
    {rst_n_i, rd, wr, bus_rst, spk, transfer_end_condition, psel} = 7'h00;
    {adr, wd, ev, clr, cnt} = 100'h0;
    err_total = 0;
    n_checks = 0;
    repeat (6) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    @(posedge core_clk_i);
    t_ien();
    t_gate();
    t_dma();
    final_report();
  end
endmodule // dev_ctrl_irq_enable_dma_config_tb
